// file: dv/spm_pins_model.sv
`include "spm_regs.svh"

module spm_pins_model (
  input  wire logic [`SPM_NUM_CELL-1:0] pin_out,
  input  wire logic [`SPM_NUM_CELL-1:0] pin_oe,
  input  wire logic [`SPM_NUM_CELL-1:0] ext_val,
  output wire logic [`SPM_NUM_CELL-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pin driven
  // the system drives its own value onto a released pin, so the wire is never left floating
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule : spm_pins_model

// file: dv/tb.sv
`include "spm_regs.svh"
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected %0t %s", $time, m); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [11:0] ded_in = 12'h000;
  logic [9:0]  ext_val = 10'h000;
  logic [9:0]  pin_in, pin_out, pin_oe, exp_q;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] seed = 32'h0000_065D;
  int          fail_count = 0, cmp_count = 0;

  spm_macrocell_array u_spm_macrocell_array (
    .aclk(aclk), .aresetn(aresetn), .ded_in(ded_in), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  spm_pins_model u_spm_pins_model (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .pin_in(pin_in)
  );

  always #25 aclk = ~aclk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [9:0] sumv(logic [11:0] d, logic [9:0] q, logic [9:0] byp, logic p0);
    return d[9:0] | {9'h000, d[10] & (byp[0] ? ~p0 : q[0])};
  endfunction : sumv

  function automatic logic [9:0] nxt(logic [11:0] d, logic [9:0] q, logic [9:0] byp, logic p0);
    if (d[9] & d[10] & d[11])
      return 10'h000;
    if (d[8] & d[10])
      return 10'h3FF;
    return sumv(d, q, byp, p0);
  endfunction : nxt

  function automatic logic [9:0] pexp(logic [11:0] d, logic [9:0] q, logic [9:0] pol,
                                      logic [9:0] byp, logic p0);
    logic [9:0] r;
    r = (byp & sumv(d, q, byp, p0)) | (~byp & ((d[9] & d[10] & d[11]) ? 10'h000 : q));
    return ~(r ^ pol);
  endfunction : pexp

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ha, hw, bd;
    int   n;
    n = 0;
    bd = 1'h0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!bd && n < 60)
    begin
      @(negedge aclk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      bd = bvalid;
      rsp = bresp;
      n++;
      @(posedge aclk);
      if (ha) awvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
    end
    // bready stays up between writes so a following call never flips it in one step
    if (!bd) fail_count++;
  endtask : axw

  task automatic axr(input logic [11:0] a);
    logic ha, rv;
    int   n;
    n = 0;
    rv = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!rv && n < 60)
    begin
      @(negedge aclk);
      ha = arvalid & arready;
      rv = rvalid;
      rd = rdata;
      rsp = rresp;
      n++;
      @(posedge aclk);
      if (ha) arvalid <= 1'h0;
    end
    // rready stays up between reads so a following call never flips it in one step
    if (!rv) fail_count++;
  endtask : axr

  task automatic cfg();
    logic [31:0] m;
    for (int t = 0; t < 92; t++)
    begin
      // spare terms tie true and complement of one input
      m = 32'h0000_0003;
      if (t < 80 && t % 8 == 0) m = 32'h0000_0001 << (t / 4);
      if (t == 1) m = 32'h0210_0000;
      if (t >= 80 && t < 90) m = 32'h0040_0000;
      if (t == 90) m = 32'h0054_0000;
      if (t == 91) m = 32'h0011_0000;
      axw(`SPM_ADDR_FUSE_BASE + 12'(8 * t), m, 4'hF);
      axw(`SPM_ADDR_FUSE_BASE + 12'(8 * t + 4), 32'h0000_0000, 4'hF);
    end
    $display("test fuse_config done");
  endtask : cfg

  task automatic run_mix(input logic [9:0] pol, input logic [9:0] byp, input logic rel);
    logic [11:0] dn;
    // all inputs low while the setup changes: every sum is zero so the registers
    // settle to zero, and no enabled bypass pin can close a loop through cell 0
    ded_in <= 12'h000;
    axw(`SPM_ADDR_CTRL, {6'h00, byp, 6'h00, pol}, 4'hF);
    axr(`SPM_ADDR_CTRL);
    `CHK(rd, {6'h00, byp, 6'h00, pol}, "ctrl readback")
    exp_q = 10'h000;
    repeat (300)
    begin
      @(posedge aclk);
      exp_q = nxt(ded_in, exp_q, byp, pin_in[0]);
      dn = 12'(xs());
      // cell 0 bypass only with pins released, else its pin feedback closes a loop
      if (rel) dn[11] = 1'h0;
      ded_in <= dn;
      ext_val <= 10'(xs());
      @(negedge aclk);
      `CHK(pin_out, pexp(ded_in, exp_q, pol, byp, pin_in[0]), "pin level")
      `CHK(pin_oe, {10{ded_in[11]}}, "pin enable")
    end
    $display("test run_mix done");
  endtask : run_mix

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    `CHK(pin_out, 10'h3FF, "reset pins")
    `CHK(pin_oe, 10'h3FF, "reset enables")
    axr(`SPM_ADDR_CTRL);
    `CHK(rd, 32'h0000_0000, "ctrl reset")
    axr(`SPM_ADDR_STATUS);
    `CHK(rd, 32'h03FF_0000, "status reset")
    axr(12'h008);
    `CHK(rsp, `SPM_RESP_SLVERR, "unmapped read")
    axw(12'h008, 32'hFFFF_FFFF, 4'hF);
    `CHK(rsp, `SPM_RESP_SLVERR, "unmapped write")
    axw(12'h104, 32'hFFFF_FFFF, 4'h3);
    axr(12'h104);
    `CHK(rd, 32'h0000_0FFF, "fuse high word")
    $display("test reset_map done");
    cfg();
    axr(12'h108);
    `CHK(rd, 32'h0210_0000, "fuse readback")
    run_mix(10'(xs()), 10'(xs()) & 10'h3FE, 1'h0);
    run_mix(10'(xs()), 10'(xs()) | 10'h001, 1'h1);
    ded_in <= 12'h500;
    repeat (2) @(posedge aclk);
    axr(`SPM_ADDR_STATUS);
    `CHK(rd, 32'h0000_03FF, "preset status")
    report_and_stop();
  end
endmodule : tb

// file: include/spm_pkg.sv
`include "spm_regs.svh"

package spm_pkg;

  typedef logic [`SPM_NUM_TERM-1:0][`SPM_NUM_COL-1:0] spm_fuse_t;

  typedef struct packed {
    spm_fuse_t                  fuse;
    logic [`SPM_NUM_CELL-1:0]   pol;
    logic [`SPM_NUM_CELL-1:0]   byp;
    logic [`SPM_NUM_CELL-1:0]   q;
    logic                       aw_held;
    logic [`SPM_ADDR_W-1:0]     awaddr;
    logic                       w_held;
    logic [31:0]                wdata;
    logic [3:0]                 wstrb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
  } spm_state_t;

  function automatic logic [31:0] spm_merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction : spm_merge

endpackage : spm_pkg

// file: include/spm_regs.svh
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH

// array geometry
`define SPM_NUM_IN          12
`define SPM_NUM_CELL        10
`define SPM_NUM_SIG         22
`define SPM_NUM_COL         44
`define SPM_SUM_PER_CELL    8
`define SPM_NUM_TERM        92
`define SPM_TERM_IDX_W      7
`define SPM_TERM_OE0        80
`define SPM_TERM_AR         90
`define SPM_TERM_SP         91

// register map, byte addresses
`define SPM_ADDR_W          12
`define SPM_ADDR_CTRL       12'h000
`define SPM_ADDR_STATUS     12'h004
`define SPM_ADDR_FUSE_BASE  12'h100
`define SPM_ADDR_FUSE_END   12'h3E0
`define SPM_FUSE_HI_BIT     2
`define SPM_FUSE_IDX_SHIFT  3
`define SPM_FUSE_LO_W       32
`define SPM_FUSE_HI_W       12

// field positions inside control and status words
`define SPM_POL_LSB         0
`define SPM_BYP_LSB         16
`define SPM_STAT_Q_LSB      0
`define SPM_STAT_OE_LSB     16

// bus answers
`define SPM_RESP_OKAY       2'h0
`define SPM_RESP_SLVERR     2'h2

`endif

// file: rtl/spm_macrocell_array.sv
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`include "spm_regs.svh"

module spm_macrocell_array (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [`SPM_NUM_IN-1:0]    ded_in,
  input  wire logic [`SPM_NUM_CELL-1:0]  pin_in,
  output wire logic [`SPM_NUM_CELL-1:0]  pin_out,
  output wire logic [`SPM_NUM_CELL-1:0]  pin_oe,
  input  wire logic [`SPM_ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output wire logic                      s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output wire logic                      s_axi_wready,
  output wire logic [1:0]                s_axi_bresp,
  output wire logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [`SPM_ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output wire logic                      s_axi_arready,
  output wire logic [31:0]               s_axi_rdata,
  output wire logic [1:0]                s_axi_rresp,
  output wire logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  import spm_pkg::*;

  spm_state_t                     st;
  spm_state_t                     next_st;

  logic [`SPM_NUM_SIG-1:0]        sig;
  logic [`SPM_NUM_COL-1:0]        cols;
  logic [`SPM_NUM_TERM-1:0]       term;
  logic [`SPM_NUM_CELL-1:0]       sop;
  logic [`SPM_NUM_CELL-1:0]       fb;
  logic [`SPM_NUM_CELL-1:0]       q_eff;
  logic [`SPM_NUM_CELL-1:0]       cell_d;
  logic                           ar_term;
  logic                           sp_term;

  logic                           wr_go;
  logic                           wr_is_ctrl;
  logic                           wr_is_status;
  logic                           wr_is_fuse;
  logic [`SPM_TERM_IDX_W-1:0]     wr_idx;
  logic [31:0]                    wr_old;
  logic [31:0]                    wr_word;
  logic [`SPM_TERM_IDX_W-1:0]     rd_idx;
  logic [31:0]                    rd_word;
  logic [1:0]                     rd_resp;
  logic [31:0]                    ctrl_word;
  logic [31:0]                    status_word;

  // dedicated inputs first, cell feedback after them
  assign sig = {fb, ded_in};

  genvar gs;
  generate
    for (gs = 0; gs < `SPM_NUM_SIG; gs++)
    begin : g_col
      assign cols[2*gs]   = sig[gs];
      assign cols[2*gs+1] = ~sig[gs];
    end
  endgenerate

  genvar gt;
  generate
    for (gt = 0; gt < `SPM_NUM_TERM; gt++)
    begin : g_term
      spm_product_term u_term (
        .cols (cols),
        .mask (st.fuse[gt]),
        .term (term[gt])
      );
    end
  endgenerate

  assign ar_term = term[`SPM_TERM_AR];
  assign sp_term = term[`SPM_TERM_SP];

  genvar gc;
  generate
    for (gc = 0; gc < `SPM_NUM_CELL; gc++)
    begin : g_cell
      assign sop[gc] = |term[gc*`SPM_SUM_PER_CELL +: `SPM_SUM_PER_CELL];
      // clear term gates the register output without waiting for the edge
      assign q_eff[gc] = st.q[gc] & ~ar_term;
      // bypass mux, zero path is the register
      assign cell_d[gc] = st.byp[gc] ? sop[gc] : q_eff[gc];
      // polarity applies after the bypass mux
      assign pin_out[gc] = st.pol[gc] ? cell_d[gc] : ~cell_d[gc];
      assign pin_oe[gc] = term[`SPM_TERM_OE0 + gc];
      // feedback follows the bypass bit
      // raw flop is used so the clear term cannot loop back into itself
      assign fb[gc] = st.byp[gc] ? pin_in[gc] : ~st.q[gc];
    end
  endgenerate

  assign ctrl_word = (32'(st.byp) << `SPM_BYP_LSB) | (32'(st.pol) << `SPM_POL_LSB);
  assign status_word = (32'(pin_oe) << `SPM_STAT_OE_LSB) | (32'(st.q) << `SPM_STAT_Q_LSB);

  assign s_axi_awready = ~st.aw_held & ~st.bvalid;
  assign s_axi_wready  = ~st.w_held & ~st.bvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = ~st.rvalid;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  assign wr_go = st.aw_held & st.w_held & ~st.bvalid;
  assign wr_idx = `SPM_TERM_IDX_W'((st.awaddr - `SPM_ADDR_FUSE_BASE) >> `SPM_FUSE_IDX_SHIFT);
  assign rd_idx = `SPM_TERM_IDX_W'((s_axi_araddr - `SPM_ADDR_FUSE_BASE) >> `SPM_FUSE_IDX_SHIFT);
  assign wr_word = spm_merge(wr_old, st.wdata, st.wstrb);

  always_comb
  begin
    wr_is_ctrl   = 1'b0;
    wr_is_status = 1'b0;
    wr_is_fuse   = 1'b0;
    wr_old       = '0;
    if (st.awaddr == `SPM_ADDR_CTRL)
    begin
      wr_is_ctrl = 1'b1;
      wr_old     = ctrl_word;
    end
    else if (st.awaddr == `SPM_ADDR_STATUS)
    begin
      wr_is_status = 1'b1;
    end
    else if (st.awaddr >= `SPM_ADDR_FUSE_BASE && st.awaddr < `SPM_ADDR_FUSE_END)
    begin
      wr_is_fuse = 1'b1;
      if (st.awaddr[`SPM_FUSE_HI_BIT])
      begin
        wr_old = 32'(st.fuse[wr_idx][`SPM_NUM_COL-1:`SPM_FUSE_LO_W]);
      end
      else
      begin
        wr_old = st.fuse[wr_idx][`SPM_FUSE_LO_W-1:0];
      end
    end
  end

  always_comb
  begin
    rd_word = '0;
    rd_resp = `SPM_RESP_OKAY;
    if (s_axi_araddr == `SPM_ADDR_CTRL)
    begin
      rd_word = ctrl_word;
    end
    else if (s_axi_araddr == `SPM_ADDR_STATUS)
    begin
      rd_word = status_word;
    end
    else if (s_axi_araddr >= `SPM_ADDR_FUSE_BASE && s_axi_araddr < `SPM_ADDR_FUSE_END)
    begin
      if (s_axi_araddr[`SPM_FUSE_HI_BIT])
      begin
        rd_word = 32'(st.fuse[rd_idx][`SPM_NUM_COL-1:`SPM_FUSE_LO_W]);
      end
      else
      begin
        rd_word = st.fuse[rd_idx][`SPM_FUSE_LO_W-1:0];
      end
    end
    else
    begin
      rd_resp = `SPM_RESP_SLVERR;
    end
  end

  always_comb
  begin
    next_st = st;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_st.aw_held = 1'b1;
      next_st.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_st.w_held = 1'b1;
      next_st.wdata  = s_axi_wdata;
      next_st.wstrb  = s_axi_wstrb;
    end
    if (wr_go)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = `SPM_RESP_OKAY;
      if (wr_is_ctrl)
      begin
        // a one in a select bit means the link is programmed
        next_st.pol = wr_word[`SPM_POL_LSB +: `SPM_NUM_CELL];
        next_st.byp = wr_word[`SPM_BYP_LSB +: `SPM_NUM_CELL];
      end
      else if (wr_is_status)
      begin
        // status is read-only, writes are dropped quietly
        next_st.bresp = `SPM_RESP_OKAY;
      end
      else if (wr_is_fuse)
      begin
        if (st.awaddr[`SPM_FUSE_HI_BIT])
        begin
          next_st.fuse[wr_idx][`SPM_NUM_COL-1:`SPM_FUSE_LO_W] = wr_word[`SPM_FUSE_HI_W-1:0];
        end
        else
        begin
          next_st.fuse[wr_idx][`SPM_FUSE_LO_W-1:0] = wr_word;
        end
      end
      else
      begin
        next_st.bresp = `SPM_RESP_SLVERR;
      end
    end
    else if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_word;
      next_st.rresp  = rd_resp;
    end
    else if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end
    if (ar_term)
    begin
      // register also clears at the edge so the gate can release cleanly
      next_st.q = '0;
    end
    else if (sp_term)
    begin
      next_st.q = '1;
    end
    else
    begin
      next_st.q = sop;
    end
  end

  // registered outputs pass the flop, the clear-term gate and a mux, so a late-settling flop
  // whose feedback the clear term takes can add extra transitions, not only stretch clock-to-output
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // registers, selects and fuse links all start clear
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking

  default disable iff (!aresetn);

  a_empty_term_high: assert property (
    (st.fuse[`SPM_TERM_SP] == '0) |-> sp_term
  ) else $error("unconnected preset term not high");

  a_conflict_term_low: assert property (
    (st.fuse[`SPM_TERM_OE0-1][0] && st.fuse[`SPM_TERM_OE0-1][1]) |-> !term[`SPM_TERM_OE0-1]
  ) else $error("term with true and complement not low");

  a_reg_capture: assert property (
    (!ar_term && !sp_term) |=> (st.q == $past(sop))
  ) else $error("register did not capture sum");

  a_preset_load: assert property (
    (sp_term && !ar_term) |=> (st.q == '1)
  ) else $error("preset did not load ones");

  a_clear_now: assert property (
    ar_term |-> (q_eff == '0) ##1 (st.q == '0)
  ) else $error("clear term did not clear registers");

  a_clear_wins: assert property (
    (ar_term && sp_term) |=> (st.q == '0)
  ) else $error("preset won over clear");

  a_reg_feedback: assert property (
    (!st.byp[0] && !st.fuse[`SPM_TERM_AR][0]) |-> (fb[0] == !st.q[0]) && (cell_d[0] == q_eff[0])
  ) else $error("registered cell feedback or output wrong");

  a_pin_feedback: assert property (
    st.byp[0] |-> (fb[0] == pin_in[0]) && (cell_d[0] == sop[0])
  ) else $error("combinatorial cell feedback or output wrong");

  a_polarity_out: assert property (
    (st.byp[1] && !st.pol[1]) |-> (pin_out[1] == !sop[1])
  ) else $error("low polarity output not inverted");

  a_reset_clear: assert property (
    $rose(aresetn) |-> (st.q == '0) && (st.byp == '0) && (st.pol == '0)
  ) else $error("state not clear after reset");

  a_enable_term: assert property (
    (st.fuse[`SPM_TERM_OE0] == '0) |-> pin_oe[0] ##1 (st.fuse[`SPM_TERM_OE0] != '0) || pin_oe[0]
  ) else $error("unconnected enable term did not drive pin");

  a_bresp_hold: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp)
  ) else $error("write response dropped before taken");

  a_read_answer: assert property (
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && (s_axi_rresp == $past(rd_resp))
  ) else $error("read answer missing");

endmodule : spm_macrocell_array

// file: rtl/spm_product_term.sv
`include "spm_regs.svh"

module spm_product_term (
  input  wire logic [`SPM_NUM_COL-1:0] cols,
  input  wire logic [`SPM_NUM_COL-1:0] mask,
  output wire logic                    term
);
  import spm_pkg::*;

  assign term = &(cols | ~mask);

endmodule : spm_product_term
